//--- verilog/ccs_top.sv
// Configuration control and status pin logic with its AXI4-Lite register file
//
// Notes on behaviour
// - Scheme chosen from static scheme-select inputs.
// - Reconfig request low: drop config, tri-state I/O.
// - Reconfig request rising starts new configuration.
// - Status line low after power-up until POR.
// - Load error pulls status line low.
// - Outside low on status line means error.
// - User mode ignores status line transitions.
// - Checker enabled: error flag high on errors.
// - Error flag open-drain when enabled, else user I/O.
// - Active serial option: tri-state its pins.
// - Active parallel option: tri-state flash pins.
// - Option set overrides dual-purpose pin settings.
// - One flash select serves both active schemes.
`timescale 1ns/1ps
module ccs_top #(
  parameter int unsigned POR_CYCLES = ccs_pkg::POR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire ccs_pkg::ccs_axi_req_t axi_req,
  output ccs_pkg::ccs_axi_rsp_t axi_rsp,
  input wire logic [2:0] scheme_select,
  input wire logic reconfig_request_n,
  input wire logic status_line_i,
  output logic status_line_o,
  output logic status_line_oe,
  input wire ccs_pkg::ccs_pins_t eng_pins,
  input wire logic [15:0] eng_data_oe,
  input wire logic eng_load_err,
  input wire logic eng_load_done,
  input wire logic eng_init_done,
  input wire logic mem_err,
  input wire ccs_pkg::ccs_pin_in_t cfg_pins_i,
  output ccs_pkg::ccs_pins_t cfg_pins_o,
  output ccs_pkg::ccs_pin_oe_t cfg_pins_oe,
  output ccs_pkg::ccs_pin_in_t eng_rx,
  output ccs_pkg::ccs_scheme_t eng_scheme,
  output logic eng_run,
  input wire logic err_flag_i,
  output logic err_flag_o,
  output logic err_flag_oe,
  output logic io_hiz,
  output logic user_mode,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (POR_CYCLES < 1) begin : g_chk
    $error("ccs_top: POR_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // State of the block, held in one record
  // ----------------------------------------------------------------
  typedef struct packed {
    ccs_pkg::ccs_state_t st;             // Configuration phase
    ccs_pkg::ccs_scheme_t scheme;        // Scheme latched at start
    logic [ccs_pkg::CTRL_W-1:0] ctrl;    // Software options
    logic [ccs_pkg::IRQ_W-1:0] irq_stat; // Sticky events
    logic [ccs_pkg::IRQ_W-1:0] irq_mask; // Event enables
    logic mem_err;                       // Registered checker result
    logic aw_got;                        // Write address held
    logic [7:0] awaddr;
    logic w_got;                         // Write data held
    logic [31:0] wdata;
    logic wstrb0;                        // Lowest byte lane enabled
    ccs_pkg::ccs_axi_rsp_t rsp;          // Bus outputs
    logic stat_oe;                       // Status line pulled low
    ccs_pkg::ccs_pins_t pins;            // Config pin levels
    ccs_pkg::ccs_pin_oe_t pins_oe;       // Config pin enables
    ccs_pkg::ccs_pin_in_t rx;            // Config pin inputs to engine
    logic err_o;
    logic err_oe;
    logic irq;
  } ccs_regs_t;

  ccs_regs_t q;            // Current state
  ccs_regs_t d;            // Next state
  logic por_done;          // Power-on interval over

  // ----------------------------------------------------------------
  // Power-on interval
  // ----------------------------------------------------------------
  ccs_timer #(
    .CYCLES(POR_CYCLES)
  ) u_por (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .expired(por_done)
  );

  // ----------------------------------------------------------------
  // Scheme decode
  // ----------------------------------------------------------------
  // Unknown codes fall back to passive serial, which drives no pin
  function automatic ccs_pkg::ccs_scheme_t decode_scheme(input logic [2:0] sel);
    ccs_pkg::ccs_scheme_t s;
    s = ccs_pkg::SCH_PS;
    if (sel == ccs_pkg::SEL_FPP) begin
      s = ccs_pkg::SCH_FPP;
    end else if (sel == ccs_pkg::SEL_AS) begin
      s = ccs_pkg::SCH_AS;
    end else if (sel == ccs_pkg::SEL_AP) begin
      s = ccs_pkg::SCH_AP;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [ccs_pkg::IRQ_W-1:0] ev;   // Events raised this cycle
    logic rd_clr;                    // Status read clears events
    logic act;                       // Active scheme, device drives
    logic drv;                       // Config pins may be driven
    ev = '0;
    rd_clr = 1'b0;
    act = 1'b0;
    drv = 1'b0;
    d = q;

    // Write channels, taken in either order
    if (axi_req.awvalid && q.rsp.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb0 = axi_req.wstrb[0];
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end

    // Both halves held: commit and answer
    if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = ccs_pkg::RESP_OKAY;
      if (q.awaddr == ccs_pkg::REG_CTRL) begin
        if (q.wstrb0) begin
          d.ctrl = q.wdata[ccs_pkg::CTRL_W-1:0];
        end
      end else if (q.awaddr == ccs_pkg::REG_IRQ_MASK) begin
        if (q.wstrb0) begin
          d.irq_mask = q.wdata[ccs_pkg::IRQ_W-1:0];
        end
      end else if (q.awaddr == ccs_pkg::REG_STATE) begin
        d.rsp.bresp = ccs_pkg::RESP_OKAY;  // Read only, write ignored
      end else if (q.awaddr == ccs_pkg::REG_IRQ_STAT) begin
        d.rsp.bresp = ccs_pkg::RESP_OKAY;  // Cleared by reading only
      end else begin
        d.rsp.bresp = ccs_pkg::RESP_SLVERR;
      end
    end

    // Read channel
    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = ccs_pkg::RESP_OKAY;
      d.rsp.rdata = '0;
      if (axi_req.araddr == ccs_pkg::REG_CTRL) begin
        d.rsp.rdata[ccs_pkg::CTRL_W-1:0] = q.ctrl;
      end else if (axi_req.araddr == ccs_pkg::REG_STATE) begin
        d.rsp.rdata[11:0] = {err_flag_i, q.mem_err, q.scheme, q.st};
      end else if (axi_req.araddr == ccs_pkg::REG_IRQ_STAT) begin
        d.rsp.rdata[ccs_pkg::IRQ_W-1:0] = q.irq_stat;
        rd_clr = 1'b1;
      end else if (axi_req.araddr == ccs_pkg::REG_IRQ_MASK) begin
        d.rsp.rdata[ccs_pkg::IRQ_W-1:0] = q.irq_mask;
      end else begin
        d.rsp.rresp = ccs_pkg::RESP_SLVERR;
      end
    end

    // Configuration phases
    case (q.st)
      ccs_pkg::ST_POR: begin
        if (por_done) begin
          d.scheme = decode_scheme(scheme_select);
          d.st = reconfig_request_n ? ccs_pkg::ST_CFG : ccs_pkg::ST_RST;
        end
      end
      ccs_pkg::ST_RST: begin
        // Request released: fresh configuration cycle
        if (reconfig_request_n) begin
          d.scheme = decode_scheme(scheme_select);
          d.st = ccs_pkg::ST_CFG;
        end
      end
      ccs_pkg::ST_CFG: begin
        if (eng_load_err) begin
          d.st = ccs_pkg::ST_ERR;
          ev[ccs_pkg::IRQ_LOADERR] = 1'b1;
        end else if (!status_line_i) begin
          d.st = ccs_pkg::ST_ERR;
          ev[ccs_pkg::IRQ_EXTERR] = 1'b1;
        end else if (eng_load_done) begin
          d.st = ccs_pkg::ST_INIT;
        end
      end
      ccs_pkg::ST_INIT: begin
        if (!status_line_i) begin
          d.st = ccs_pkg::ST_ERR;
          ev[ccs_pkg::IRQ_EXTERR] = 1'b1;
        end else if (eng_init_done) begin
          d.st = ccs_pkg::ST_USER;
          ev[ccs_pkg::IRQ_USER] = 1'b1;
        end
      end
      ccs_pkg::ST_USER: begin
        d.st = ccs_pkg::ST_USER;
      end
      ccs_pkg::ST_ERR: begin
        d.st = ccs_pkg::ST_ERR;  // Held until a reconfiguration request
      end
      default: begin
        d.st = ccs_pkg::ST_POR;
      end
    endcase

    // Only the request pin restarts; status line alone never does
    if (!reconfig_request_n && q.st != ccs_pkg::ST_POR) begin
      d.st = ccs_pkg::ST_RST;
      if (q.st != ccs_pkg::ST_RST) begin
        ev[ccs_pkg::IRQ_RECFG] = 1'b1;
      end
    end

    // New memory error is the event
    d.mem_err = mem_err;
    if (q.ctrl[ccs_pkg::CTRL_ERRCHK] && mem_err && !q.mem_err) begin
      ev[ccs_pkg::IRQ_MEMERR] = 1'b1;
    end

    // Sticky events: a new event beats a clearing read
    d.irq_stat = (rd_clr ? '0 : q.irq_stat) | ev;

    // Status line: low through power-up, reset hold and error
    d.stat_oe = (d.st == ccs_pkg::ST_POR) ||
                (d.st == ccs_pkg::ST_RST) ||
                (d.st == ccs_pkg::ST_ERR);

    // Config pin drive
    act = (d.scheme == ccs_pkg::SCH_AS) || (d.scheme == ccs_pkg::SCH_AP);
    if (d.st == ccs_pkg::ST_CFG || d.st == ccs_pkg::ST_INIT) begin
      drv = 1'b1;
    end else if (d.st == ccs_pkg::ST_USER) begin
      // Tri-state option outranks the dual-purpose choice
      drv = !d.ctrl[ccs_pkg::CTRL_TRIST] &&
            d.ctrl[ccs_pkg::CTRL_DPDRV];
    end
    d.pins = eng_pins;
    d.pins_oe.cfg_shift_clock = drv && act;
    d.pins_oe.flash_select = drv && act;
    d.pins_oe.serial_command_out = drv && (d.scheme == ccs_pkg::SCH_AS);
    d.pins_oe.flash_ctl = drv && (d.scheme == ccs_pkg::SCH_AP);
    d.pins_oe.data = (drv && (d.scheme == ccs_pkg::SCH_AP)) ?
                     eng_data_oe : '0;
    d.rx = cfg_pins_i;

    // Error flag pin
    if (d.ctrl[ccs_pkg::CTRL_ERRCHK]) begin
      // Open drain: pull low while clean, release high on error
      d.err_o = 1'b0;
      d.err_oe = !d.mem_err;
    end else begin
      d.err_o = d.ctrl[ccs_pkg::CTRL_UIO_OUT];
      d.err_oe = d.ctrl[ccs_pkg::CTRL_UIO_OE];
    end

    // Handshake readies follow the held items
    d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
    d.rsp.wready = !d.w_got && !d.rsp.bvalid;
    d.rsp.arready = !d.rsp.rvalid;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset: power-on phase, status line low, pins off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= ccs_pkg::ST_POR;
      q.scheme <= ccs_pkg::SCH_PS;
      q.ctrl <= ccs_pkg::CTRL_RST;
      q.irq_stat <= ccs_pkg::IRQ_RST;
      q.irq_mask <= ccs_pkg::IRQ_RST;
      q.stat_oe <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from the state register except the status line level, which is tied low
  // ----------------------------------------------------------------
  assign axi_rsp = q.rsp;
  assign status_line_o = q.pins.flash_reset_n & 1'b0;
  assign status_line_oe = q.stat_oe;
  assign cfg_pins_o = q.pins;
  assign cfg_pins_oe = q.pins_oe;
  assign eng_rx = q.rx;
  assign eng_scheme = q.scheme;
  assign eng_run = (q.st == ccs_pkg::ST_CFG) || (q.st == ccs_pkg::ST_INIT);
  assign err_flag_o = q.err_o;
  assign err_flag_oe = q.err_oe;
  assign io_hiz = (q.st != ccs_pkg::ST_USER);
  assign user_mode = (q.st == ccs_pkg::ST_USER);
  assign irq = q.irq;

endmodule

//--- inc/ccs_pkg.sv
// Constants and carrier types for the config control and status block
package ccs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;            // System clock rate
  localparam int unsigned POR_TIME_NS = 100000;     // Power-on reset interval, ns
  // Round up to whole cycles
  localparam int unsigned POR_CYCLES = (POR_TIME_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;          // Options, read/write
  localparam logic [7:0] REG_STATE = 8'h04;         // Block state, read only
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;      // Sticky events, read clears
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;      // Interrupt enables

  // Control bits
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_ERRCHK = 0;          // Memory error checker on
  localparam int unsigned CTRL_TRIST = 1;           // Tri-state cfg pins in user mode
  localparam int unsigned CTRL_DPDRV = 2;           // Dual-purpose: keep driving
  localparam int unsigned CTRL_UIO_OUT = 3;         // Error pin as user I/O: level
  localparam int unsigned CTRL_UIO_OE = 4;          // Error pin as user I/O: enable
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Event bits, shared by status and mask
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_LOADERR = 0;          // Load error seen
  localparam int unsigned IRQ_EXTERR = 1;           // Status line pulled low outside
  localparam int unsigned IRQ_MEMERR = 2;           // Stored bits found corrupt
  localparam int unsigned IRQ_USER = 3;             // User mode entered
  localparam int unsigned IRQ_RECFG = 4;            // Reconfiguration requested
  localparam logic [4:0] IRQ_RST = 5'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Scheme-select codes and decoded schemes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_PS = 3'h0;
  localparam logic [2:0] SEL_FPP = 3'h1;
  localparam logic [2:0] SEL_AS = 3'h2;
  localparam logic [2:0] SEL_AP = 3'h3;

  typedef enum logic [3:0] {
    SCH_PS = 4'h1,
    SCH_FPP = 4'h2,
    SCH_AS = 4'h4,
    SCH_AP = 4'h8
  } ccs_scheme_t;

  typedef enum logic [5:0] {
    ST_POR = 6'h01,
    ST_RST = 6'h02,
    ST_CFG = 6'h04,
    ST_INIT = 6'h08,
    ST_USER = 6'h10,
    ST_ERR = 6'h20
  } ccs_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cfg_shift_clock;
    logic flash_select_n;
    logic serial_command_out;
    logic flash_reset_n;
    logic address_valid_n;
    logic flash_read_strobe_n;
    logic flash_write_strobe_n;
    logic [23:0] flash_address_out;
    logic [15:0] data;
  } ccs_pins_t;

  typedef struct packed {
    logic cfg_shift_clock;
    logic flash_select;
    logic serial_command_out;
    logic flash_ctl;                                // Address and strobes
    logic [15:0] data;
  } ccs_pin_oe_t;

  typedef struct packed {
    logic cfg_shift_clock;
    logic [15:0] data;
  } ccs_pin_in_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ccs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccs_axi_rsp_t;

endpackage

//--- verilog/ccs_timer.sv
// Down-counter marking the end of an interval after reset
`timescale 1ns/1ps
module ccs_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  output logic expired
);

  localparam int unsigned CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES - 1);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CYCLES < 1) begin : g_chk
    $error("ccs_timer: CYCLES must be at least one");
  end

  logic [CNT_W-1:0] cnt_q;  // Cycles left

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  // Expired stays high until the next reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= CNT_LOAD;
      expired <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end else begin
        expired <= 1'b1;
      end
    end
  end

endmodule

//--- test/ccs_top_assertions.sv
// Port checks for the config control and status block
`timescale 1ns/1ps
module ccs_top_assertions #(
  parameter int unsigned POR_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire ccs_pkg::ccs_axi_req_t axi_req,
  input wire ccs_pkg::ccs_axi_rsp_t axi_rsp,
  input wire logic reconfig_request_n,
  input wire logic status_line_i,
  input wire logic status_line_oe,
  input wire logic eng_load_err,
  input wire ccs_pkg::ccs_pin_oe_t cfg_pins_oe,
  input wire ccs_pkg::ccs_scheme_t eng_scheme,
  input wire logic eng_run,
  input wire logic io_hiz,
  input wire logic user_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Enabled edges since reset, saturating
  // ----------------------------------------------------------------
  int unsigned edges_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      edges_q <= 0;
    end else if (clk_en && edges_q <= POR_CYCLES) begin
      edges_q <= edges_q + 1;
    end
  end

  // ----------------------------------------------------------------
  // Multi-step behaviours
  // ----------------------------------------------------------------
  // Request low then high, after power-on
  sequence s_req_pulse;
    !reconfig_request_n && clk_en && edges_q > POR_CYCLES ##1 reconfig_request_n && clk_en;
  endsequence
  // AW and W taken together
  sequence s_both_taken;
    clk_en && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence

  a_por_hold_low: assert property (edges_q <= POR_CYCLES |-> status_line_oe && !eng_run)
    else $error("status line released early");
  a_por_release: assert property (edges_q == POR_CYCLES + 1 && $past(edges_q) == POR_CYCLES
    && $past(reconfig_request_n) |-> !status_line_oe)
    else $error("status line held late");
  a_req_resets: assert property (!reconfig_request_n && clk_en
    |=> io_hiz && !user_mode && !eng_run && status_line_oe)
    else $error("request low did not reset");
  a_restart_cfg: assert property (s_req_pulse |=> eng_run && !status_line_oe)
    else $error("rise did not start loading");
  a_user_ignores: assert property (user_mode && reconfig_request_n |=> user_mode)
    else $error("user mode left");
  a_ext_low_err: assert property (eng_run && clk_en && !status_line_i
    |=> !eng_run && status_line_oe)
    else $error("outside low ignored");
  a_oe_rise_cause: assert property ($rose(status_line_oe)
    |-> $past(eng_load_err || !status_line_i || !reconfig_request_n))
    else $error("pull without cause");
  a_idle_pins: assert property (io_hiz && !eng_run |-> cfg_pins_oe == '0)
    else $error("pins driven while idle");
  a_passive_clk: assert property (eng_scheme inside {ccs_pkg::SCH_PS, ccs_pkg::SCH_FPP}
    |-> !cfg_pins_oe.cfg_shift_clock && !cfg_pins_oe.flash_select)
    else $error("passive scheme drives clock");
  a_serial_pins: assert property (eng_run && eng_scheme == ccs_pkg::SCH_AS
    |-> cfg_pins_oe.flash_select && cfg_pins_oe.serial_command_out && !cfg_pins_oe.flash_ctl)
    else $error("serial enables wrong");
  a_parallel_pins: assert property (eng_run && eng_scheme == ccs_pkg::SCH_AP
    |-> cfg_pins_oe.flash_select && cfg_pins_oe.flash_ctl && cfg_pins_oe.cfg_shift_clock)
    else $error("parallel enables wrong");
  a_read_latency: assert property (clk_en && axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_both_taken |=> ##1 axi_rsp.bvalid)
    else $error("write answer late");
endmodule

bind ccs_top ccs_top_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (.clk_sys, .sys_rst,
  .clk_en, .axi_req, .axi_rsp, .reconfig_request_n, .status_line_i, .status_line_oe,
  .eng_load_err, .cfg_pins_oe, .eng_scheme, .eng_run, .io_hiz, .user_mode);

//--- test/ccs_host_model.sv
// Host model: request pin and shared open-drain lines
`timescale 1ns/1ps
module ccs_host_model (
  input wire logic clk_sys,
  input wire logic req_low,
  input wire logic ext_pull,
  input wire logic status_line_o,
  input wire logic status_line_oe,
  input wire logic err_flag_o,
  input wire logic err_flag_oe,
  output logic reconfig_request_n,
  output logic status_line_i,
  output logic err_flag_i
);
  logic pull_q; // Our own pull on the status line
  initial begin
    reconfig_request_n = 1'h1;
    pull_q = 1'h0;
  end
  // Host pins change after the edge; restart only by request pulse
  always @(posedge clk_sys) begin
    reconfig_request_n <= !req_low;
    pull_q <= ext_pull;
  end
  // Pull-up wire: low while any party pulls it
  assign status_line_i = !(pull_q || (status_line_oe && !status_line_o));
  // Error pin pull-up
  assign err_flag_i = err_flag_oe ? err_flag_o : 1'h1;
endmodule

//--- test/ccs_top_bench.sv
// Self-checking bench for the config control and status block
`timescale 1ns/1ps
module ccs_top_bench;
  localparam int unsigned POR = 8; // Short power-on interval
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  ccs_pkg::ccs_axi_req_t axi_req = '0;
  ccs_pkg::ccs_axi_rsp_t axi_rsp;
  ccs_pkg::ccs_axi_rsp_t rsp_s; // Answer as seen at the coming edge
  logic [2:0] scheme_select = 3'h3;
  logic req_low = 1'h0;
  logic ext_pull = 1'h0;
  logic eng_load_err = 1'h0;
  logic eng_load_done = 1'h0;
  logic eng_init_done = 1'h0;
  logic mem_err = 1'h0;
  logic reconfig_request_n, status_line_i, status_line_o, status_line_oe, eng_run;
  logic err_flag_i, err_flag_o, err_flag_oe, io_hiz, user_mode, irq;
  ccs_pkg::ccs_pin_oe_t cfg_pins_oe;
  ccs_pkg::ccs_scheme_t eng_scheme;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  logic [3:0] hot [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
  logic [31:0] rd;
  logic [1:0] rsp;
  logic act;
  int n_fail = 0;
  int comparisons = 0;
  wire [3:0] oe4 = {cfg_pins_oe.cfg_shift_clock, cfg_pins_oe.flash_select,
    cfg_pins_oe.serial_command_out, cfg_pins_oe.flash_ctl};

  always #2 clk_sys = ~clk_sys;
  // Answers sampled at the falling edge
  always @(negedge clk_sys) rsp_s = axi_rsp;

  ccs_top #(.POR_CYCLES(POR)) DUT (.clk_sys, .sys_rst, .clk_en(1'h1), .axi_req, .axi_rsp,
    .scheme_select, .reconfig_request_n, .status_line_i, .status_line_o, .status_line_oe,
    .eng_pins('0), .eng_data_oe(16'hFFFF), .eng_load_err, .eng_load_done, .eng_init_done,
    .mem_err, .cfg_pins_i('0), .cfg_pins_o(), .cfg_pins_oe, .eng_rx(), .eng_scheme, .eng_run,
    .err_flag_i, .err_flag_o, .err_flag_oe, .io_hiz, .user_mode, .irq);

  ccs_host_model host (.clk_sys, .req_low, .ext_pull, .status_line_o, .status_line_oe,
    .err_flag_o, .err_flag_oe, .reconfig_request_n, .status_line_i, .err_flag_i);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write: AW and W together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'h1;
    axi_req.wvalid <= 1'h1;
    axi_req.bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (rsp_s.awready) axi_req.awvalid <= 1'h0;
      if (rsp_s.wready) axi_req.wvalid <= 1'h0;
    end while (!rsp_s.bvalid);
    rsp = rsp_s.bresp;
    axi_req.bready <= 1'h0;
  endtask
  // Read, compare data and response
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge clk_sys);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'h1;
    axi_req.rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (rsp_s.arready) axi_req.arvalid <= 1'h0;
    end while (!rsp_s.rvalid);
    axi_req.rready <= 1'h0;
    chk(w, e, rsp_s.rdata);
    chk(w, er, rsp_s.rresp);
  endtask
  // Request pulse; scheme moves only while low
  task automatic pulse(input logic [2:0] code);
    wt(1);
    req_low <= 1'h1;
    wt(3);
    scheme_select <= code;
    wt(3);
    req_low <= 1'h0;
    wt(4);
  endtask
  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    wt(20000);
    n_fail++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    wt(8);
    sys_rst <= 1'h0;
    wt(POR);
    #1 chk("status hold", 1'h1, status_line_oe);
    wt(3);
    #1 chk("status free", 1'h0, status_line_oe);
    rchk("ctrl", ccs_pkg::REG_CTRL, 32'h0, ccs_pkg::RESP_OKAY);
    rchk("mask", ccs_pkg::REG_IRQ_MASK, 32'h0, ccs_pkg::RESP_OKAY);
    rchk("hole", 8'h10, 32'h0, ccs_pkg::RESP_SLVERR);
    wr(8'h10, 32'hFFFF);
    chk("hole wr", ccs_pkg::RESP_SLVERR, rsp);
    wr(ccs_pkg::REG_STATE, 32'hFFFF);
    rchk("state", ccs_pkg::REG_STATE, {20'h0, 2'h2, ccs_pkg::SCH_AP, ccs_pkg::ST_CFG},
      ccs_pkg::RESP_OKAY);
    wr(ccs_pkg::REG_IRQ_MASK, 32'h1);
    // Load error
    eng_load_err <= 1'h1;
    wt(1);
    eng_load_err <= 1'h0;
    wt(2);
    #1 chk("err pull", 1'h1, status_line_oe);
    chk("irq up", 1'h1, irq);
    rchk("stat", ccs_pkg::REG_IRQ_STAT, 32'h1, ccs_pkg::RESP_OKAY);
    wt(3);
    #1 chk("irq down", 1'h0, irq);
    // Outside pull; its release must not restart
    pulse(3'h2);
    ext_pull <= 1'h1;
    wt(3);
    #1 chk("ext err", 1'h0, eng_run);
    wt(1);
    ext_pull <= 1'h0;
    wt(4);
    #1 chk("err stays", 1'h0, eng_run);
    chk("masked", 1'h0, irq);
    rchk("stat", ccs_pkg::REG_IRQ_STAT, 32'h12, ccs_pkg::RESP_OKAY);
    // Each scheme code to user mode; pins kept driven for code 2 only, tri-stated for the rest
    for (int i = 0; i < 5; i++) begin
      wr(ccs_pkg::REG_CTRL, i == 2 ? 32'h4 : 32'h6);
      pulse(codes[i]);
      #1 chk("scheme", hot[i], eng_scheme);
      chk("run", 1'h1, eng_run);
      act = hot[i][2] | hot[i][3];
      chk("cfg pins", {act, act, hot[i][2], hot[i][3]}, oe4);
      wt(1);
      eng_load_done <= 1'h1;
      eng_init_done <= 1'h1;
      wt(2);
      eng_load_done <= 1'h0;
      eng_init_done <= 1'h0;
      wt(2);
      #1 chk("user", 1'h1, user_mode);
      chk("io on", 1'h0, io_hiz);
      chk("user pins", i == 2 ? {act, act, hot[i][2], hot[i][3]} : 4'h0, oe4);
      wt(1);
      ext_pull <= 1'h1;
      wt(3);
      #1 chk("ignore line", 1'h1, user_mode);
      wt(1);
      ext_pull <= 1'h0;
    end
    // Request low in user mode
    req_low <= 1'h1;
    wt(3);
    #1 chk("drop user", 1'h0, user_mode);
    chk("io off", 1'h1, io_hiz);
    wt(1);
    req_low <= 1'h0;
    wt(4);
    // Error flag: checker, user I/O, off
    wr(ccs_pkg::REG_CTRL, 32'h1);
    wt(3);
    #1 chk("flag idle", 2'h1, {err_flag_o, err_flag_oe});
    wt(1);
    mem_err <= 1'h1;
    wt(3);
    #1 chk("flag high", 1'h1, err_flag_i);
    wt(1);
    mem_err <= 1'h0;
    wr(ccs_pkg::REG_CTRL, 32'h18);
    wt(3);
    #1 chk("flag uio", 2'h3, {err_flag_o, err_flag_oe});
    wr(ccs_pkg::REG_CTRL, 32'h0);
    wt(3);
    #1 chk("flag off", 1'h0, err_flag_oe);
    results();
  end
endmodule
